// ===== pkg/spindle_defines.svh
`ifndef SPINDLE_DEFINES_SVH
`define SPINDLE_DEFINES_SVH

// ********************************************************
// Timing
// ********************************************************
`define CLK_PERIOD_NS     10
`define DRV_RESET_TIME_NS 10000
`define DRV_RESET_CYCLES  (`DRV_RESET_TIME_NS / `CLK_PERIOD_NS)
`define CHARGE_TIME_NS    1000000
`define CHARGE_CYCLES     (`CHARGE_TIME_NS / `CLK_PERIOD_NS)
`define REF_PERIOD_NS     11111000
`define REF_CYCLES        (`REF_PERIOD_NS / `CLK_PERIOD_NS)
`define TIMEOUT_TIME_NS   100000000
`define TIMEOUT_CYCLES    (`TIMEOUT_TIME_NS / `CLK_PERIOD_NS)

// ********************************************************
// Register offsets
// ********************************************************
`define OFS_CTRL    8'h00
`define OFS_STATUS  8'h04
`define OFS_MASK    8'h08
`define OFS_MODE    8'h0c
`define OFS_PERIOD  8'h10
`define OFS_TIMEOUT 8'h14
`define OFS_GAIN    8'h18
`define OFS_SIXTH   8'h1c

// ********************************************************
// Fields and reset values
// ********************************************************
`define CTRL_RUN_BIT   0
`define ST_FAIL_BIT    0
`define ST_ACCEL_BIT   1
`define ST_STABLE_BIT  2
`define GAIN_RESET     8'h40
`define SIXTH_RESET    8'h04

`endif

// ===== pkg/spindle_pkg.sv
`default_nettype none
package spindle_pkg;
    // Sequencer states
    typedef enum logic [2:0] {
        st_off,
        st_drv_reset,
        st_charge,
        st_start,
        st_accel,
        st_stable
    } state_t;
    // Spindle control modes
    typedef enum logic [1:0] {
        mode_idle,
        mode_start,
        mode_accel,
        mode_stable
    } mode_t;
endpackage
`default_nettype wire

// ===== rtl/spindle_speed_sequencer.sv
// What this block does
// - The sequencer is always in exactly one of idle, start, acceleration or stable mode.
// - After the driver reset time it first drives the charge request so the driver pump sets motor current.
// - After the charge time it drives the start command so current flows into the motor.
// - With no feedback within the timeout in start, the driver is reset and start repeats.
// - Feedback received in start mode moves the sequencer to acceleration.
// - In acceleration the commutation request is dropped and the driver commutates alone.
// - Speed is measured from feedback and 5,400 rpm moves the sequencer to stable mode.
// - In stable mode the revolution time is compared with the 11.111 ms reference.
// - Faster than reference discharges, slower charges, for the difference times gain k.
// - A correction is applied once every sixth of a revolution.
`include "spindle_defines.svh"
`default_nettype none
module spindle_speed_sequencer
    import spindle_pkg::*;
#(
    parameter int unsigned CHARGE_CYCLES = `CHARGE_CYCLES,
    parameter int unsigned TIMEOUT_RESET = `TIMEOUT_CYCLES,
    parameter int unsigned REF_CYCLES    = `REF_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        phase_fb,
    output logic             drv_reset,
    output logic             drv_charge,
    output logic             drv_discharge,
    output logic             drv_start,
    output logic             drv_commutate,
    output logic             irq
);

    // ********************************************************
    // Bus slave
    // ********************************************************
    // Timing constants cut to the counter width
    localparam logic [23:0] REF_P  = REF_CYCLES[23:0];
    localparam logic [23:0] CHG_P  = CHARGE_CYCLES[23:0];
    localparam logic [23:0] RST_P  = 24'(`DRV_RESET_CYCLES);
    localparam logic [23:0] TOUT_P = TIMEOUT_RESET[23:0];

    // Settings, status and bus capture storage
    logic        run;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [23:0] timeout;
    logic [7:0]  gain;
    logic [7:0]  sixth;
    logic [23:0] rev_period;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    state_t      state;

    // Address phase decode, write strobes in the data phase
    wire       acc    = hsel & htrans[1] & hready;
    wire [7:0] a_ofs  = haddr[7:0];
    wire       wr_ctl = wr_pend & (wr_addr == `OFS_CTRL);
    wire       wr_st  = wr_pend & (wr_addr == `OFS_STATUS);
    wire       wr_msk = wr_pend & (wr_addr == `OFS_MASK);
    wire       wr_to  = wr_pend & (wr_addr == `OFS_TIMEOUT);
    wire       wr_gn  = wr_pend & (wr_addr == `OFS_GAIN);
    wire       wr_sx  = wr_pend & (wr_addr == `OFS_SIXTH);

    mode_t mode;
    // Mode seen by software, one at a time
    // mode from state
    assign mode = (state == st_accel)  ? mode_accel  :
                  (state == st_stable) ? mode_stable :
                  (state == st_off)    ? mode_idle   : mode_start;

    // Read mux, unmapped reads as zero
    wire [31:0] rd_mux =
        (a_ofs == `OFS_CTRL)    ? {31'h0, run}                       :
        (a_ofs == `OFS_STATUS)  ? {29'h0, status}                    :
        (a_ofs == `OFS_MASK)    ? {29'h0, mask}                      :
        (a_ofs == `OFS_MODE)    ? {25'h0, 2'(mode), 2'h0, 3'(state)} :
        (a_ofs == `OFS_PERIOD)  ? {8'h0, rev_period}                 :
        (a_ofs == `OFS_TIMEOUT) ? {8'h0, timeout}                    :
        (a_ofs == `OFS_GAIN)    ? {24'h0, gain}                      :
        (a_ofs == `OFS_SIXTH)   ? {24'h0, sixth}                     : 32'h0;

    // Address phase capture, read data loaded here
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= acc & hwrite;
            wr_addr   <= a_ofs;
            hrdata    <= (acc & ~hwrite) ? rd_mux : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Settings registers
    // software settings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run     <= 1'b0;
            mask    <= 3'h0;
            timeout <= TOUT_P;
            gain    <= `GAIN_RESET;
            sixth   <= `SIXTH_RESET;
        end else begin
            if (wr_ctl) run <= hwdata[`CTRL_RUN_BIT];
            if (wr_msk) mask <= hwdata[2:0];
            if (wr_to) timeout <= hwdata[23:0];
            if (wr_gn) gain <= hwdata[7:0];
            if (wr_sx) sixth <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
        end
    end

    // ********************************************************
    // Sequencer
    // ********************************************************
    // Sequencer timers, counters and next state
    logic        fb_prev;
    logic [23:0] tmr;
    logic [23:0] seg_cnt;
    logic [7:0]  pulse_cnt;
    logic [23:0] corr_cnt;
    logic        corr_dis;
    state_t      next_state;

    // Start, acceleration or stable rotation: driver under way
    function automatic logic spinning(input state_t s);
        return (s == st_start) || (s == st_accel) || (s == st_stable);
    endfunction

    // Feedback rise and end of a sixth
    // At or past the count, so a smaller setting cannot strand a segment
    wire fb_rise   = phase_fb & ~fb_prev;
    wire sixth_end = fb_rise & (pulse_cnt >= sixth - 8'h01);

    // Revolution estimate: six sixths, saturated
    wire [26:0] rev_wide = {1'b0, seg_cnt, 2'b00} + {2'b00, seg_cnt, 1'b0};
    wire [23:0] rev_est  = (|rev_wide[26:24]) ? 24'hffffff : rev_wide[23:0];
    wire        faster   = rev_est < REF_P;
    wire [23:0] diff     = faster ? (REF_P - rev_est) : (rev_est - REF_P);
    wire [31:0] prod     = {8'h00, diff} * {24'h0, gain};
    wire [23:0] corr_len = prod[31:8];
    wire        tmr_out  = (tmr == 24'h0);
    wire        fb_lost  = seg_cnt >= timeout;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            st_off:       next_state = run ? st_drv_reset : st_off;
            st_drv_reset: next_state = tmr_out ? st_charge : st_drv_reset;
            st_charge:    next_state = tmr_out ? st_start : st_charge;
            st_start: begin
                if (fb_rise) next_state = st_accel;
                else if (tmr_out) next_state = st_drv_reset;
            end
            st_accel: begin
                if (fb_lost) next_state = st_drv_reset;
                else if (sixth_end && !(rev_est > REF_P)) next_state = st_stable;
            end
            st_stable:    next_state = fb_lost ? st_drv_reset : st_stable;
            default:      next_state = st_off;
        endcase
        if (!run) next_state = st_off;
    end

    // Transition events for status and timer
    wire enter      = next_state != state;
    wire fail_evt   = run & (((state == st_start) & tmr_out & ~fb_rise) |
                      (((state == st_accel) | (state == st_stable)) & fb_lost));
    wire accel_evt  = run & (state == st_start) & fb_rise;
    wire stable_evt = run & (state == st_accel) & (next_state == st_stable);

    // Phase timer reload on each state entry
    wire [23:0] next_tmr =
        !enter                      ? (tmr_out ? tmr : tmr - 24'h1) :
        (next_state == st_drv_reset) ? RST_P - 24'h1 :
        (next_state == st_charge)    ? CHG_P - 24'h1 :
        (next_state == st_start)     ? timeout : 24'h0;

    // State and phase timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= st_off;
            tmr     <= 24'h0;
            fb_prev <= 1'b0;
        end else begin
            state   <= next_state;
            tmr     <= next_tmr;
            fb_prev <= phase_fb;
        end
    end

    // Segment timing over one sixth revolution
    // one sixth per segment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seg_cnt    <= 24'h0;
            pulse_cnt  <= 8'h00;
            rev_period <= 24'h0;
        end else if (enter || sixth_end) begin
            // The marking edge is the first cycle of the new segment
            seg_cnt    <= 24'h1;
            pulse_cnt  <= 8'h00;
            rev_period <= sixth_end ? rev_est : rev_period;
        end else begin
            seg_cnt    <= (seg_cnt == 24'hffffff) ? seg_cnt : seg_cnt + 24'h1;
            pulse_cnt  <= fb_rise ? pulse_cnt + 8'h01 : pulse_cnt;
        end
    end

    // Correction pulse, restarted each sixth
    // charge or discharge pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            corr_cnt <= 24'h0;
            corr_dis <= 1'b0;
        end else if (state != st_stable) begin
            corr_cnt <= 24'h0;
            corr_dis <= 1'b0;
        end else if (sixth_end) begin
            corr_cnt <= corr_len;
            corr_dis <= faster;
        end else if (corr_cnt != 24'h0) begin
            corr_cnt <= corr_cnt - 24'h1;
        end
    end

    // Sticky events, set beats write-one clear
    // stable, acceleration and failure events
    wire [2:0] evt = {stable_evt, accel_evt, fail_evt};
    // Status value that will stand next cycle, also feeds the interrupt
    wire [2:0] next_st_irq = evt | (status & ~(wr_st ? hwdata[2:0] : 3'h0));
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status <= 3'h0;
        end else begin
            status <= next_st_irq;
        end
    end

    // ********************************************************
    // Driver outputs
    // ********************************************************
    wire next_reset = (next_state == st_off) | (next_state == st_drv_reset);
    // Correction pulses only while rotation stays stable
    wire keep_stable = (state == st_stable) & (next_state == st_stable);

    wire next_chg   = (next_state == st_charge) | (next_state == st_start) |
                      (keep_stable & (corr_cnt > 24'h1) & ~corr_dis) |
                      (keep_stable & sixth_end & ~faster & (corr_len != 24'h0));
    wire next_dis   = (keep_stable & (corr_cnt > 24'h1) & corr_dis) |
                      (keep_stable & sixth_end & faster & (corr_len != 24'h0));
    wire next_start = spinning(next_state);
    wire next_comm  = next_state == st_start;

    // Driver commands, registered from the next state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drv_reset     <= 1'b1;
            drv_charge    <= 1'b0;
            drv_discharge <= 1'b0;
            drv_start     <= 1'b0;
            drv_commutate <= 1'b0;
            irq           <= 1'b0;
        end else begin
            drv_reset     <= next_reset;
            drv_charge    <= next_chg & ~next_dis;
            drv_discharge <= next_dis;
            drv_start     <= next_start;
            drv_commutate <= next_comm;
            irq           <= |(next_st_irq & mask);
        end
    end

    // Bus fields this slave does not decode
    wire unused = &{1'b0, hsize, haddr[31:8]};

endmodule
`default_nettype wire

// ===== tb/spindle_speed_sequencer_assertions.sv
`default_nettype none
// ********************************
// Spindle sequencer port checks
// ********************************
module spindle_speed_sequencer_assertions #(
    parameter int unsigned CHARGE_CYCLES = 20,
    parameter int unsigned TIMEOUT_RESET = 200
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic phase_fb,
    input wire logic drv_reset,
    input wire logic drv_charge,
    input wire logic drv_discharge,
    input wire logic drv_start,
    input wire logic drv_commutate
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [15:0] rst_run;
    logic [15:0] chg_run;
    logic [31:0] com_run;
    // Run lengths of reset, charge and forced commutation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_run <= 16'h0000;
            chg_run <= 16'h0000;
            com_run <= 32'h0;
        end else begin
            rst_run <= !drv_reset ? 16'h0000 : (rst_run < 16'h07d0) ? rst_run + 16'h0001 : rst_run;
            chg_run <= !(drv_charge && !drv_start) ? 16'h0000 : chg_run + 16'h0001;
            com_run <= !drv_commutate ? 32'h0 : com_run + 32'h1;
        end
    end
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_pump_exclusive: assert property (!(drv_charge && drv_discharge))
        else $error("charge and discharge together");
    a_reset_quiet: assert property (drv_reset |-> !(drv_start || drv_commutate || drv_discharge))
        else $error("driver commanded while held in reset");
    a_reset_length: assert property ($fell(drv_reset) |-> rst_run >= 16'h03e7)
        else $error("driver reset too short");
    a_charge_first: assert property ($rose(drv_start) |->
        chg_run >= CHARGE_CYCLES - 2 && chg_run <= CHARGE_CYCLES + 1)
        else $error("start without full charge time");
    a_commut_levels: assert property (drv_commutate |-> drv_start && drv_charge)
        else $error("forced commutation outside start state");
    a_start_timeout: assert property (com_run <= TIMEOUT_RESET + 2)
        else $error("start state outlived its timeout");
    a_fb_accel: assert property ($rose(phase_fb) && drv_commutate |-> ##[1:6] !drv_commutate)
        else $error("feedback did not end start state");
    a_accel_keeps: assert property ($fell(drv_commutate) && !drv_reset |-> drv_start)
        else $error("start command lost on leaving start");
    a_fix_stable: assert property (drv_discharge |-> drv_start && !drv_commutate)
        else $error("discharge outside stable rotation");
endmodule
bind spindle_speed_sequencer spindle_speed_sequencer_assertions #(
    .CHARGE_CYCLES(CHARGE_CYCLES), .TIMEOUT_RESET(TIMEOUT_RESET)
) chk_inst (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .phase_fb(phase_fb), .drv_reset(drv_reset), .drv_charge(drv_charge),
    .drv_discharge(drv_discharge), .drv_start(drv_start), .drv_commutate(drv_commutate));
`default_nettype wire

// ===== tb/spindle_driver_model.sv
`default_nettype none
// ********************************
// Analog spindle driver stand-in
// ********************************
module spindle_driver_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       drv_reset,
    input  wire logic       drv_start,
    input  wire logic [7:0] gap,
    output var  logic       phase_fb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt;
    logic [2:0] step;
    // five-step order, one back-EMF pulse per gap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt      <= 8'h00;
            step     <= 3'h0;
            phase_fb <= 1'h0;
        end else if (drv_reset || !drv_start || gap == 8'h00) begin
            cnt      <= 8'h00;
            phase_fb <= 1'h0;
        end else if (cnt >= gap - 8'h01) begin
            cnt      <= 8'h00;
            step     <= (step == 3'h4) ? 3'h0 : step + 3'h1;
            phase_fb <= 1'h1;
        end else begin
            cnt      <= cnt + 8'h01;
            phase_fb <= phase_fb && cnt == 8'h00;
        end
    end
endmodule
`default_nettype wire

// ===== tb/spindle_speed_sequencer_test.sv
`include "spindle_defines.svh"
`default_nettype none
// ********************************
// Spindle sequencer bench
// ********************************
module spindle_speed_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
`define CHECK_EQ(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch %s expected %h seen %h", n, e, g); end end
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, phase_fb, irq;
    logic        drv_reset, drv_charge, drv_discharge, drv_start, drv_commutate;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  gap;
    int          err_total, total_checks, nchg, ndis, plen;
    int          cycles = 0;
    assign hready = hreadyout;
    spindle_speed_sequencer #(.CHARGE_CYCLES(20), .TIMEOUT_RESET(200), .REF_CYCLES(600))
    spindle_speed_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .phase_fb(phase_fb),
        .drv_reset(drv_reset), .drv_charge(drv_charge), .drv_discharge(drv_discharge),
        .drv_start(drv_start), .drv_commutate(drv_commutate), .irq(irq));
    spindle_driver_model spindle_driver_model_inst (.hclk(hclk), .hresetn(hresetn),
        .drv_reset(drv_reset), .drv_start(drv_start), .gap(gap), .phase_fb(phase_fb));
    // Clock and hang guard
    initial begin
        hclk = 1'h0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            final_report();
        end
    end
    // One single AHB-Lite transfer, read data kept in rd
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'h1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
        ahb(1'h0, a, 32'h0);
        `CHECK_EQ(n, e, rd)
    endtask
    // Bounded wait for reset (1) or commutate (0) to reach a level
    task automatic wait_lvl(input int i, input logic v);
        logic [1:0] w;
        for (int k = 0; k < 5000; k++) begin
            @(posedge hclk);
            #1;
            w = {drv_reset, drv_commutate};
            if (w[i] === v) break;
        end
        @(posedge hclk);
    endtask
    // Pulse rises and longest pulse over a window
    task automatic count_pulses(input int n);
        logic pc, pd;
        int run;
        nchg = 0;
        ndis = 0;
        plen = 0;
        run = 0;
        repeat (n) begin
            pc = drv_charge;
            pd = drv_discharge;
            @(posedge hclk);
            #1;
            nchg += int'(drv_charge && !pc);
            ndis += int'(drv_discharge && !pd);
            run = (drv_charge || drv_discharge) ? run + 1 : 0;
            plen = (run > plen) ? run : plen;
        end
        @(posedge hclk);
    endtask
    task automatic t_reset();
        `CHECK_EQ("reset_levels", 2'h2, {drv_reset, drv_start})
        rd_chk(`OFS_MODE, 32'h0, "mode_idle");
        rd_chk(`OFS_GAIN, 32'h40, "gain");
        rd_chk(`OFS_SIXTH, 32'h4, "sixth");
        rd_chk(`OFS_TIMEOUT, 32'hc8, "timeout");
        rd_chk(8'h20, 32'h0, "unmapped");
    endtask
    task automatic t_timeout();
        ahb(1'h1, `OFS_MASK, 32'h1);
        ahb(1'h1, `OFS_CTRL, 32'h1);
        wait_lvl(0, 1'h1);
        rd_chk(`OFS_MODE, 32'h23, "mode_start");
        wait_lvl(1, 1'h1);
        rd_chk(`OFS_STATUS, 32'h1, "status_fail");
        `CHECK_EQ("irq_fail", 1'h1, irq)
        ahb(1'h1, `OFS_MASK, 32'h0);
        ahb(1'h1, `OFS_STATUS, 32'h1);
        repeat (3) @(posedge hclk);
        `CHECK_EQ("irq_clear", 1'h0, irq)
        wait_lvl(1, 1'h0);
        repeat (3) @(posedge hclk);
        `CHECK_EQ("charge_first", 2'h2, {drv_charge, drv_start})
        wait_lvl(1, 1'h1);
        rd_chk(`OFS_STATUS, 32'h1, "status_again");
        `CHECK_EQ("irq_masked", 1'h0, irq)
    endtask
    task automatic t_accel();
        ahb(1'h1, `OFS_STATUS, 32'h1);
        ahb(1'h1, `OFS_MASK, 32'h2);
        gap <= 8'h1e;
        wait_lvl(0, 1'h1);
        wait_lvl(0, 1'h0);
        repeat (400) @(posedge hclk);
        rd_chk(`OFS_MODE, 32'h44, "mode_accel");
        `CHECK_EQ("self_commutate", 2'h1, {drv_commutate, drv_start})
        rd_chk(`OFS_STATUS, 32'h2, "status_accel");
        `CHECK_EQ("irq_accel", 1'h1, irq)
    endtask
    task automatic t_stable();
        gap <= 8'h19;
        repeat (400) @(posedge hclk);
        rd_chk(`OFS_MODE, 32'h65, "mode_stable");
        rd_chk(`OFS_PERIOD, 32'h258, "period");
        count_pulses(800);
        `CHECK_EQ("pulses_ref", 64'h0, {nchg, ndis})
        gap <= 8'h14;
        repeat (300) @(posedge hclk);
        count_pulses(800);
        `CHECK_EQ("pulses_fast", 64'ha, {nchg, ndis})
        `CHECK_EQ("width_fast", 1'h1, plen inside {29, 30})
        gap <= 8'h1c;
        repeat (300) @(posedge hclk);
        count_pulses(896);
        `CHECK_EQ("pulses_slow", 64'h800000000, {nchg, ndis})
        `CHECK_EQ("width_slow", 1'h1, plen inside {17, 18})
        ahb(1'h1, `OFS_GAIN, 32'h0);
        repeat (300) @(posedge hclk);
        count_pulses(896);
        `CHECK_EQ("pulses_gain0", 64'h0, {nchg, ndis})
    endtask
    task automatic t_stop();
        ahb(1'h1, `OFS_SIXTH, 32'h0);
        rd_chk(`OFS_SIXTH, 32'h1, "sixth_min");
        ahb(1'h1, `OFS_CTRL, 32'h0);
        wait_lvl(1, 1'h1);
        rd_chk(`OFS_MODE, 32'h0, "mode_off");
    endtask
    task automatic final_report();
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        gap = 8'h00;
        repeat (16) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        t_reset();
        t_timeout();
        t_accel();
        t_stable();
        t_stop();
        final_report();
    end
endmodule
`default_nettype wire
